// ---- pkg/alu_pkg.sv ----
// Constants, operation codes and field layout shared by the byte datapath files
package alu_pkg;
	// ---------------------------------------------------------------
	// Widths and field positions
	// ---------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int DATA_MSB   = 7;
	localparam int ADDR_W     = 7;
	localparam int NIB_W      = 4;
	localparam int NIB_LO_MSB = 3;
	localparam int NIB_HI_LSB = 4;
	localparam int DIR_COUNT  = 3;
	localparam int DIR_IDX_W  = 2;

	// ---------------------------------------------------------------
	// Operand ranges and reset values
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0]    FILE_ADDR_MAX = 7'h7f;
	localparam logic [ADDR_W-1:0]    DIR_SEL_FIRST = 7'h05;
	localparam logic [ADDR_W-1:0]    DIR_SEL_LAST  = 7'h07;
	localparam logic [DATA_W-1:0]    ACC_RESET     = 8'h00;
	localparam logic [DATA_W-1:0]    DIR_RESET     = 8'hff;
	localparam logic [DATA_W-1:0]    ZERO_BYTE     = 8'h00;
	localparam logic [ADDR_W-1:0]    ADDR_RESET    = 7'h00;
	localparam logic                 FLAG_RESET    = 1'b0;
	localparam logic                 DEST_ACC      = 1'b0;
	localparam logic                 DEST_FILE     = 1'b1;

	// ---------------------------------------------------------------
	// Operation codes, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		subtract_acc_from_file = 6'h01,
		subtract_with_borrow   = 6'h02,
		nibble_swap_op         = 6'h04,
		xor_literal_op         = 6'h08,
		xor_file_op            = 6'h10,
		load_direction_op      = 6'h20
	} alu_op_t;
endpackage

// ---- pkg/dir_if.sv ----
// Interface between the datapath and its port-direction register bank
`timescale 1ns/10ps
interface dir_if;
	import alu_pkg::*;
	logic                              wr;
	logic [DIR_IDX_W-1:0]              sel;
	logic [DATA_W-1:0]                 data;
	logic [DIR_COUNT-1:0][DATA_W-1:0]  dir;

	modport master (output wr, output sel, output data, input dir);
	modport bank   (input wr, input sel, input data, output dir);
endinterface

// ---- logic/direction_bank.sv ----
// Bank of port-direction registers written from the accumulator
`timescale 1ns/10ps
module direction_bank (
	input  wire logic clock, // Core clock
	input  wire logic ce,    // Clock enable, freezes state when low
	input  wire logic rst,   // Synchronous reset, active high
	dir_if.bank       dbus   // Write port and register contents
);
	import alu_pkg::*;

	// ---------------------------------------------------------------
	// One register per port
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < DIR_COUNT; i++) begin : g_dir
			logic [DATA_W-1:0] dir_q;
			logic [DATA_W-1:0] dir_d;
			always_comb begin
				dir_d = dir_q;
				if (dbus.wr && (dbus.sel == DIR_IDX_W'(i))) begin
					dir_d = dbus.data;
				end
			end
			always_ff @(posedge clock) begin
				if (rst) begin
					dir_q <= DIR_RESET;
				end else if (ce) begin
					dir_q <= dir_d;
				end
			end
			assign dbus.dir[i] = dir_q;
		end
	endgenerate
endmodule

// ---- logic/byte_alu.sv ----
// Execution datapath: subtract, subtract with borrow, nibble swap, xor, direction load
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Subtract from file computes file minus accumulator and sends it to acc (d=0) or file (d=1), address up to 127.
// - After subtract, carry is clear when acc exceeds file, nibble carry likewise on low nibbles, zero from result.
// - Subtract with borrow also takes away the inverted carry and updates carry, nibble carry and zero.
// - Subtract with borrow sends its result to acc when d is 0 and to the file register when d is 1.
// - Nibble swap exchanges the two halves of the file byte and leaves every flag alone.
// - Nibble swap sends the swapped byte to acc when d is 0 and to the file register when d is 1.
// - Xor literal combines acc with an 8-bit immediate, stores in acc and changes only zero.
// - Direction load copies acc into port A, B or C direction for operand 5, 6 or 7, flags untouched.
// - Xor file combines acc with the file byte, routes by d and changes only zero.
module byte_alu (
	input  wire logic                          clock,             // Core clock, 50 MHz
	input  wire logic                          ce,                // Clock enable
	input  wire logic                          rst,               // Synchronous reset, high
	input  wire logic                          op_valid,          // Operation issued this cycle
	input  wire alu_pkg::alu_op_t              op_code,           // One-hot operation code
	input  wire logic                          dest_bit,          // 0 to acc, 1 to file
	input  wire logic [alu_pkg::ADDR_W-1:0]    file_addr,         // File address or direction select
	input  wire logic [alu_pkg::DATA_W-1:0]    file_rd_data,      // Addressed file register value
	input  wire logic [alu_pkg::DATA_W-1:0]    literal,           // Immediate operand
	output logic      [alu_pkg::DATA_W-1:0]    acc,               // Accumulator
	output logic                               carry_flag,        // Carry, inverse of borrow
	output logic                               nibble_carry_flag, // Low-nibble carry
	output logic                               zero_flag,         // Result was zero
	output logic                               file_we,           // File write pulse
	output logic      [alu_pkg::ADDR_W-1:0]    file_wr_addr,      // File write address
	output logic      [alu_pkg::DATA_W-1:0]    file_wr_data,      // File write data
	output logic                               op_done,           // Operation completed pulse
	output logic                               op_error,          // Bad code or selector pulse
	output logic      [alu_pkg::DATA_W-1:0]    port_a_direction,  // Port A direction
	output logic      [alu_pkg::DATA_W-1:0]    port_b_direction,  // Port B direction
	output logic      [alu_pkg::DATA_W-1:0]    port_c_direction   // Port C direction
);
	import alu_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] acc_q, acc_d;
	logic              carry_q, carry_d;
	logic              nib_q, nib_d;
	logic              zero_q, zero_d;
	logic              we_q, we_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic              done_q, done_d;
	logic              err_q, err_d;

	logic [DATA_W:0]   diff_full;
	logic [NIB_W:0]    diff_low;
	logic              borrow;
	logic [DATA_W-1:0] result;
	logic              route;
	logic              addr_ok;

	dir_if dbus ();

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		acc_d     = acc_q;
		carry_d   = carry_q;
		nib_d     = nib_q;
		zero_d    = zero_q;
		we_d      = 1'b0;
		waddr_d   = waddr_q;
		wdata_d   = wdata_q;
		done_d    = 1'b0;
		err_d     = 1'b0;
		borrow    = 1'b0;
		result    = ZERO_BYTE;
		route     = 1'b0;
		diff_full = '0;
		diff_low  = '0;
		dbus.wr   = 1'b0;
		dbus.sel  = '0;
		dbus.data = acc_q;
		addr_ok   = (file_addr <= FILE_ADDR_MAX);
		if (op_valid) begin
			done_d = 1'b1;
			case (op_code)
				subtract_acc_from_file, subtract_with_borrow: begin
					// Carry holds not-borrow, so the borrow in is its inverse
					if (op_code == subtract_with_borrow) begin
						borrow = ~carry_q;
					end
					diff_full = {1'b0, file_rd_data} - {1'b0, acc_q}
						- {{DATA_W{1'b0}}, borrow};
					diff_low  = {1'b0, file_rd_data[NIB_LO_MSB:0]}
						- {1'b0, acc_q[NIB_LO_MSB:0]} - {{NIB_W{1'b0}}, borrow};
					result  = diff_full[DATA_MSB:0];
					carry_d = ~diff_full[DATA_W];
					nib_d   = ~diff_low[NIB_W];
					zero_d  = (result == ZERO_BYTE);
					route   = 1'b1;
				end
				nibble_swap_op: begin
					result = {file_rd_data[NIB_LO_MSB:0],
						file_rd_data[DATA_MSB:NIB_HI_LSB]};
					route  = 1'b1;
				end
				xor_literal_op: begin
					result = acc_q ^ literal;
					acc_d  = result;
					zero_d = (result == ZERO_BYTE);
				end
				xor_file_op: begin
					result = acc_q ^ file_rd_data;
					zero_d = (result == ZERO_BYTE);
					route  = 1'b1;
				end
				load_direction_op: begin
					// Selectors outside 5..7 load nothing and are reported
					if ((file_addr >= DIR_SEL_FIRST) && (file_addr <= DIR_SEL_LAST)) begin
						dbus.wr  = 1'b1;
						dbus.sel = DIR_IDX_W'(file_addr - DIR_SEL_FIRST);
					end else begin
						err_d = 1'b1;
					end
				end
				default: begin
					done_d = 1'b0;
					err_d  = 1'b1;
				end
			endcase
			if (route) begin
				if (dest_bit == DEST_FILE) begin
					we_d    = addr_ok;
					waddr_d = file_addr;
					wdata_d = result;
					err_d   = ~addr_ok;
				end else begin
					acc_d = result;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			acc_q   <= ACC_RESET;
			carry_q <= FLAG_RESET;
			nib_q   <= FLAG_RESET;
			zero_q  <= FLAG_RESET;
			we_q    <= 1'b0;
			waddr_q <= ADDR_RESET;
			wdata_q <= ZERO_BYTE;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
		end else if (ce) begin
			acc_q   <= acc_d;
			carry_q <= carry_d;
			nib_q   <= nib_d;
			zero_q  <= zero_d;
			we_q    <= we_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			done_q  <= done_d;
			err_q   <= err_d;
		end
	end

	direction_bank u_dir (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.dbus  (dbus.bank)
	);

	assign acc               = acc_q;
	assign carry_flag        = carry_q;
	assign nibble_carry_flag = nib_q;
	assign zero_flag         = zero_q;
	assign file_we           = we_q;
	assign file_wr_addr      = waddr_q;
	assign file_wr_data      = wdata_q;
	assign op_done           = done_q;
	assign op_error          = err_q;
	assign port_a_direction  = dbus.dir[0];
	assign port_b_direction  = dbus.dir[1];
	assign port_c_direction  = dbus.dir[2];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence issue_s(alu_op_t op);
		ce && op_valid && (op_code == op);
	endsequence
	sequence to_acc_s(alu_op_t op);
		issue_s(op) && (dest_bit == DEST_ACC);
	endsequence
	sequence to_file_s(alu_op_t op);
		issue_s(op) && (dest_bit == DEST_FILE);
	endsequence

	sub_carry_a: assert property (issue_s(subtract_acc_from_file) |=>
		(carry_q == ($past(acc_q) <= $past(file_rd_data)))
		&& (nib_q == ($past(acc_q[NIB_LO_MSB:0]) <= $past(file_rd_data[NIB_LO_MSB:0]))))
		else $error("subtract flags wrong");
	sub_acc_a: assert property (to_acc_s(subtract_acc_from_file) |=>
		(acc_q == DATA_W'($past(file_rd_data) - $past(acc_q))) && !we_q)
		else $error("subtract to acc wrong");
	sub_file_a: assert property (to_file_s(subtract_acc_from_file) |=>
		we_q && (wdata_q == DATA_W'($past(file_rd_data) - $past(acc_q)))
		&& (acc_q == $past(acc_q)))
		else $error("subtract to file wrong");
	subb_value_a: assert property (to_acc_s(subtract_with_borrow) |=>
		acc_q == DATA_W'($past(file_rd_data) - $past(acc_q) - {7'h00, ~$past(carry_q)}))
		else $error("borrow subtract wrong");
	// The write pulse may only stand a second cycle when a new op was issued meanwhile
	subb_route_a: assert property (to_file_s(subtract_with_borrow)
		&& (file_addr <= FILE_ADDR_MAX) |=> we_q && (waddr_q == $past(file_addr))
		##1 (!we_q || $past(op_valid && ce)))
		else $error("borrow subtract routing wrong");
	subb_flags_a: assert property (issue_s(subtract_with_borrow) |=>
		carry_q == ({1'b0, $past(file_rd_data)}
		>= ({1'b0, $past(acc_q)} + {{DATA_W{1'b0}}, ~$past(carry_q)})))
		else $error("borrow subtract carry wrong");
	swap_flags_a: assert property (issue_s(nibble_swap_op) |=>
		$stable(carry_q) && $stable(nib_q) && $stable(zero_q)
		&& (wdata_q[DATA_MSB:NIB_HI_LSB] == $past(file_rd_data[NIB_LO_MSB:0]) || !we_q))
		else $error("swap touched flags");
	swap_acc_a: assert property (to_acc_s(nibble_swap_op) |=>
		acc_q == {$past(file_rd_data[NIB_LO_MSB:0]), $past(file_rd_data[DATA_MSB:NIB_HI_LSB])})
		else $error("swap to acc wrong");
	xorl_a: assert property (issue_s(xor_literal_op) |=>
		(acc_q == ($past(acc_q) ^ $past(literal))) && $stable(carry_q) && !we_q)
		else $error("xor literal wrong");
	dir_load_a: assert property (issue_s(load_direction_op) && (file_addr == DIR_SEL_FIRST)
		|=> (port_a_direction == $past(acc_q)) && $stable(port_b_direction) && $stable(zero_q))
		else $error("direction load wrong");
	xorf_a: assert property (to_file_s(xor_file_op) |=>
		(wdata_q == ($past(acc_q) ^ $past(file_rd_data))) && $stable(nib_q))
		else $error("xor file wrong");
	zero_flag_a: assert property ((issue_s(xor_file_op) or issue_s(subtract_with_borrow))
		|=> zero_q == (($past(dest_bit) == DEST_FILE) ? (wdata_q == ZERO_BYTE)
		: (acc_q == ZERO_BYTE)))
		else $error("zero flag wrong");
	xorl_zero_a: assert property (issue_s(xor_literal_op) |=>
		zero_q == (acc_q == ZERO_BYTE))
		else $error("xor literal zero wrong");
	swap_file_a: assert property (to_file_s(nibble_swap_op) |=> we_q
		&& (waddr_q == $past(file_addr)) && (acc_q == $past(acc_q))
		&& (wdata_q == {$past(file_rd_data[NIB_LO_MSB:0]),
		$past(file_rd_data[DATA_MSB:NIB_HI_LSB])}))
		else $error("swap to file wrong");
	xorf_acc_a: assert property (to_acc_s(xor_file_op) |=>
		(acc_q == ($past(acc_q) ^ $past(file_rd_data))) && !we_q && $stable(carry_q))
		else $error("xor file to acc wrong");
	dir_load_b_a: assert property (issue_s(load_direction_op)
		&& (file_addr == DIR_SEL_FIRST + 7'h01)
		|=> (port_b_direction == $past(acc_q)) && $stable(port_a_direction)
		&& $stable(port_c_direction) && $stable(carry_q))
		else $error("direction b load wrong");
	dir_load_c_a: assert property (issue_s(load_direction_op)
		&& (file_addr == DIR_SEL_LAST)
		|=> (port_c_direction == $past(acc_q)) && $stable(port_a_direction)
		&& $stable(port_b_direction) && $stable(nib_q))
		else $error("direction c load wrong");
	// Selectors outside the port range must leave every direction register alone
	dir_range_a: assert property (issue_s(load_direction_op)
		&& ((file_addr < DIR_SEL_FIRST) || (file_addr > DIR_SEL_LAST))
		|=> op_error && $stable(port_a_direction) && $stable(port_b_direction)
		&& $stable(port_c_direction))
		else $error("direction selector not refused");
	bad_code_a: assert property (ce && op_valid && !$onehot(op_code) |=>
		op_error && !op_done && !we_q && $stable(acc_q) && $stable(zero_q))
		else $error("bad code not refused");
	// A low enable must hold acc, carry, zero, the write pulse and port A direction
	freeze_a: assert property (!ce |=> $stable(acc_q) && $stable(carry_q)
		&& $stable(zero_q) && $stable(we_q) && $stable(port_a_direction))
		else $error("state moved with enable low");
	idle_a: assert property (ce && !op_valid |=> !we_q && !op_done && !op_error)
		else $error("pulse without an issued op");
endmodule

// ---- testbench/file_model.sv ----
// Behavioural data register file on the far side of the datapath
`timescale 1ns/10ps
module file_model (
	input  wire logic                       clock,   // Core clock
	input  wire logic [alu_pkg::ADDR_W-1:0] rd_addr, // Read address
	output logic      [alu_pkg::DATA_W-1:0] rd_data, // Read value
	input  wire logic                       we,      // Write pulse
	input  wire logic [alu_pkg::ADDR_W-1:0] wr_addr, // Write address
	input  wire logic [alu_pkg::DATA_W-1:0] wr_data  // Write value
);
	import alu_pkg::*;
	logic [DATA_W-1:0] mem [0:127];
	// Reads are combinational so the value stands in the issue cycle
	assign rd_data = mem[rd_addr];
	// Filled with a pattern so no read ever returns an unknown
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = DATA_W'(i) ^ 8'ha5;
		end
	end
	always @(posedge clock) begin
		if (we) begin
			mem[wr_addr] <= wr_data;
		end
	end
	task automatic poke(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		mem[a] = v;
	endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the byte datapath
`timescale 1ns/10ps
module testbench;
	import alu_pkg::*;
	typedef struct {alu_op_t op; logic d; logic [6:0] a; logic [7:0] k; logic [7:0] f;} row_t;
	logic clock, ce, rst, op_valid, dest_bit, cf, ncf, zf, we, done, err;
	alu_op_t op_code;
	logic [6:0] file_addr, wa;
	logic [7:0] rd, literal, acc, wd, pa, pb, pc;
	logic [7:0] e_acc, e_wd, e_dir [0:2];
	logic [6:0] e_wa;
	logic e_c, e_dc, e_z, e_we;
	int fails, comparisons;
	row_t rows [0:14] = '{
		'{xor_literal_op, 1'b0, 7'h00, 8'h3c, 8'h00}, '{subtract_acc_from_file, 1'b1, 7'h7f, 8'h00, 8'h50},
		'{subtract_acc_from_file, 1'b0, 7'h10, 8'h00, 8'h20}, '{subtract_with_borrow, 1'b0, 7'h11, 8'h00, 8'hff},
		'{subtract_with_borrow, 1'b1, 7'h12, 8'h00, 8'h1a}, '{nibble_swap_op, 1'b0, 7'h13, 8'h00, 8'ha5},
		'{nibble_swap_op, 1'b1, 7'h14, 8'h00, 8'h0f}, '{xor_file_op, 1'b1, 7'h15, 8'h00, 8'h5a},
		'{xor_file_op, 1'b0, 7'h16, 8'h00, 8'h0f}, '{load_direction_op, 1'b0, 7'h05, 8'h00, 8'h00},
		'{xor_literal_op, 1'b0, 7'h00, 8'h0f, 8'h00}, '{load_direction_op, 1'b0, 7'h06, 8'h00, 8'h00},
		'{xor_literal_op, 1'b0, 7'h00, 8'h3c, 8'h00}, '{load_direction_op, 1'b0, 7'h07, 8'h00, 8'h00},
		'{xor_literal_op, 1'b0, 7'h00, 8'h66, 8'h00}};
	byte_alu dut (.clock(clock), .ce(ce), .rst(rst), .op_valid(op_valid), .op_code(op_code),
		.dest_bit(dest_bit), .file_addr(file_addr), .file_rd_data(rd), .literal(literal),
		.acc(acc), .carry_flag(cf), .nibble_carry_flag(ncf), .zero_flag(zf), .file_we(we),
		.file_wr_addr(wa), .file_wr_data(wd), .op_done(done), .op_error(err),
		.port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc));
	file_model model (.clock(clock), .rd_addr(file_addr), .rd_data(rd), .we(we),
		.wr_addr(wa), .wr_data(wd));
	// ---------------------------------------------------------------
	// Reference and checking tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic step(input row_t r);
		logic [8:0] t;
		logic [4:0] n;
		logic [7:0] res;
		logic b;
		b = (r.op == subtract_with_borrow) ? ~e_c : 1'b0;
		e_we = 1'b0;
		t = {1'b0, r.f} - {1'b0, e_acc} - 9'(b);
		n = {1'b0, r.f[3:0]} - {1'b0, e_acc[3:0]} - 5'(b);
		res = (r.op == nibble_swap_op) ? {r.f[3:0], r.f[7:4]} : (r.op == xor_file_op) ? e_acc ^ r.f : t[7:0];
		if (r.op == xor_literal_op) begin
			e_acc = e_acc ^ r.k;
			e_z = (e_acc == 8'h00);
		end else if (r.op == load_direction_op && r.a >= 7'h05 && r.a <= 7'h07) begin
			e_dir[r.a - 7'h05] = e_acc;
		end else if (r.op inside {subtract_acc_from_file, subtract_with_borrow, nibble_swap_op, xor_file_op}) begin
			if (r.op != nibble_swap_op) begin
				e_z = (res == 8'h00);
			end
			if (r.op != nibble_swap_op && r.op != xor_file_op) begin
				e_c = ~t[8];
				e_dc = ~n[4];
			end
			e_we = r.d;
			e_wa = r.a;
			e_wd = res;
			if (!r.d) begin
				e_acc = res;
			end
		end
	endtask
	task automatic clear_exp();
		e_acc = ACC_RESET;
		{e_c, e_dc, e_z, e_we} = 4'h0;
		e_dir = '{DIR_RESET, DIR_RESET, DIR_RESET};
	endtask
	task automatic check_all(input logic dn, input logic er);
		check(acc, e_acc);
		check({5'h00, cf, ncf, zf}, {5'h00, e_c, e_dc, e_z});
		check({5'h00, we, done, err}, {5'h00, e_we, dn, er});
		if (e_we) begin
			check({1'b0, wa}, {1'b0, e_wa});
			check(wd, e_wd);
		end
		check(pa, e_dir[0]);
		check(pb, e_dir[1]);
		check(pc, e_dir[2]);
	endtask
	task automatic drive(input row_t r);
		@(posedge clock);
		model.poke(r.a, r.f);
		op_valid <= 1'b1;
		op_code <= r.op;
		dest_bit <= r.d;
		file_addr <= r.a;
		literal <= r.k;
		step(r);
	endtask
	task automatic run(input row_t r, input logic dn, input logic er);
		drive(r);
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
		check_all(dn, er);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Stimulus
	// ---------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		finish_test();
	end
	initial begin
		{rst, ce, op_valid, dest_bit, file_addr, literal} = {1'b1, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00};
		op_code = xor_literal_op;
		fails = 0;
		comparisons = 0;
		clear_exp();
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		#1;
		check_all(1'b0, 1'b0);
		foreach (rows[i]) begin
			run(rows[i], 1'b1, 1'b0);
		end
		// Code with two bits set must be refused and leave state alone
		run('{alu_op_t'(6'h03), 1'b0, 7'h20, 8'h5a, 8'h33}, 1'b0, 1'b1);
		// Selector below the direction range loads nothing
		run('{load_direction_op, 1'b0, 7'h04, 8'h00, 8'h00}, 1'b1, 1'b1);
		run('{xor_literal_op, 1'b0, 7'h00, 8'h80, 8'h00}, 1'b1, 1'b0);
		// Enable low: the issued op is lost and nothing moves
		@(posedge clock);
		ce <= 1'b0;
		op_valid <= 1'b1;
		op_code <= xor_literal_op;
		literal <= 8'hff;
		@(posedge clock);
		op_valid <= 1'b0;
		ce <= 1'b1;
		#1;
		check_all(1'b0, 1'b0);
		// Borrow chain issued back to back, carry from the first feeds the second
		drive('{subtract_acc_from_file, 1'b0, 7'h21, 8'h00, 8'h10});
		drive('{subtract_with_borrow, 1'b0, 7'h22, 8'h00, 8'h00});
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
		check_all(1'b1, 1'b0);
		// Reset in mid-run restores every register
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		#1;
		clear_exp();
		check_all(1'b0, 1'b0);
		run('{xor_literal_op, 1'b0, 7'h00, 8'h81, 8'h00}, 1'b1, 1'b0);
		finish_test();
	end
endmodule
